// File: core/rcs_supervisor.sv
// Reset supervision, calibration, frequency test and battery monitor.
// Assumes APB master on pclk; osc_tick, supply_ok and battery_below are
// synchronous; both pins drive low only, with external pull-ups.
`timescale 1ns/10ps

module rcs_supervisor
  import rcs_pkg::*;
#(
  parameter int unsigned SLOW_QUAL = SLOW_QUAL_CYC,
  parameter int unsigned HOLD = HOLD_CYC,
  parameter int unsigned BATT_SECS = BATT_INTERVAL_S
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator and supply monitors
  input wire logic osc_tick,
  input wire logic supply_ok,
  input wire logic battery_below,
  // Reset requests
  input wire logic fast_reset_request_n,
  input wire logic slow_reset_request_n,
  // Reset output, open drain
  input wire logic reset_out_i,
  output logic reset_out_o,
  output logic reset_out_oe,
  // Interrupt and frequency test output, open drain
  input wire logic interrupt_freqtest_out_i,
  output logic interrupt_freqtest_out_o,
  output logic interrupt_freqtest_out_oe
);

  localparam int HOLD_W = $clog2(HOLD + 1);
  localparam int BATT_W = $clog2(BATT_SECS + 1);
  localparam int FT_W = $clog2(FT_HALF_TICKS);

  logic fast_qual;
  logic slow_qual;
  logic any_req;
  logic reset_active;
  logic reset_clear;
  logic [HOLD_W-1:0] hold_cnt;
  logic supply_q;
  logic power_up;
  logic power_down;
  logic wr_ok;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [7:0] alarm_month;
  logic [7:0] watchdog;
  logic [7:0] control;
  logic [7:0] seconds;
  logic [7:0] day;
  logic osc_run;
  logic sec_tick;
  logic [FT_W-1:0] ft_cnt;
  logic ft_wave;
  logic ft_cond;
  logic [BATT_W-1:0] batt_secs;
  logic interval_done;
  logic check_pending;
  logic check_now;
  logic battery_low_flag;

  // --------------------------------------------------------------------------
  // Reset request qualification
  // --------------------------------------------------------------------------
  rcs_low_filter #(
    .QUAL(FAST_QUAL_CYC)
  ) u_fast_filter (
    .pclk(pclk),
    .presetn(presetn),
    .req_n(fast_reset_request_n),
    .qualified(fast_qual)
  );

  rcs_low_filter #(
    .QUAL(SLOW_QUAL)
  ) u_slow_filter (
    .pclk(pclk),
    .presetn(presetn),
    .req_n(slow_reset_request_n),
    .qualified(slow_qual)
  );

  // Supply loss acts like a request, so both paths share one release timer
  assign any_req = fast_qual | slow_qual | ~supply_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_active <= 1'b1;
      hold_cnt <= '0;
    end else if (any_req) begin
      reset_active <= 1'b1;
      hold_cnt <= '0;
    end else if (reset_active && hold_cnt == HOLD_W'(HOLD - 1)) begin
      reset_active <= 1'b0;
      hold_cnt <= '0;
    end else if (reset_active) begin
      hold_cnt <= hold_cnt + HOLD_W'(1);
    end
  end

  assign reset_out_o = 1'b0;
  assign reset_out_oe = reset_active;
  // Alarm bits are kept while the supply is down, cleared once it returns
  assign reset_clear = reset_active & supply_ok;

  // --------------------------------------------------------------------------
  // Supply edges
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_q <= 1'b0;
    end else begin
      supply_q <= supply_ok;
    end
  end

  assign power_up = supply_ok & ~supply_q;
  assign power_down = ~supply_ok & supply_q;

  // --------------------------------------------------------------------------
  // APB slave: zero wait states, read data captured in the setup cycle
  // --------------------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_ok = psel & penable & pwrite & pstrb[0] & supply_ok;

  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (paddr)
      reg_addr(IDX_FLAGS_STATUS): rd_byte[BL_BIT] = battery_low_flag;
      reg_addr(IDX_ALARM_MONTH_CONTROL): rd_byte = alarm_month;
      reg_addr(IDX_WATCHDOG_SETTING): rd_byte = watchdog;
      reg_addr(IDX_CONTROL_CALIBRATION): rd_byte = control;
      reg_addr(IDX_SECONDS_AND_STOP): rd_byte = seconds;
      reg_addr(IDX_DAY_AND_FREQ_TEST): rd_byte = day;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= {24'h00_0000, rd_byte};
      pslverr <= ~rd_hit;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_month <= REG_RESET;
    end else if (reset_clear) begin
      alarm_month[AFE_BIT] <= 1'b0;
      alarm_month[ABE_BIT] <= 1'b0;
      alarm_month[SQUARE_WAVE_ENABLE_BIT] <= 1'b0;
    end else if (wr_ok && paddr == reg_addr(IDX_ALARM_MONTH_CONTROL)) begin
      alarm_month <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog <= REG_RESET;
    end else if (reset_clear || power_down) begin
      watchdog <= REG_RESET;
    end else if (wr_ok && paddr == reg_addr(IDX_WATCHDOG_SETTING)) begin
      watchdog <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= REG_RESET;
    end else if (reset_clear || power_down) begin
      control[W_BIT] <= 1'b0;
      control[R_BIT] <= 1'b0;
    end else if (wr_ok && paddr == reg_addr(IDX_CONTROL_CALIBRATION)) begin
      control <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seconds <= REG_RESET;
    end else if (wr_ok && paddr == reg_addr(IDX_SECONDS_AND_STOP)) begin
      seconds <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      day <= REG_RESET;
    end else if (reset_clear || power_down) begin
      day[FT_BIT] <= 1'b0;
    end else if (wr_ok && paddr == reg_addr(IDX_DAY_AND_FREQ_TEST)) begin
      day <= pwdata[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Calibrated divider and frequency test
  // --------------------------------------------------------------------------
  assign osc_run = osc_tick & ~seconds[ST_BIT];

  rcs_cal_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .osc_run(osc_run),
    .cal_mag(control[CAL_MAG_W-1:0]),
    .cal_pos(control[SIGN_BIT]),
    .sec_tick(sec_tick)
  );

  // Test wave counts raw oscillator cycles, untouched by calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft_cnt <= '0;
      ft_wave <= 1'b0;
    end else if (osc_run) begin
      ft_cnt <= ft_cnt + FT_W'(1);
      if (ft_cnt == FT_W'(FT_HALF_TICKS - 1)) begin
        ft_wave <= ~ft_wave;
      end
    end
  end

  assign ft_cond = ~seconds[ST_BIT] & day[FT_BIT] & ~alarm_month[AFE_BIT] &
    (watchdog[WDS_BIT] | (watchdog == 8'h00));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_freqtest_out_oe <= 1'b0;
    end else begin
      interrupt_freqtest_out_oe <= ft_cond & ~ft_wave;
    end
  end

  assign interrupt_freqtest_out_o = 1'b0;

  // --------------------------------------------------------------------------
  // Battery monitor
  // --------------------------------------------------------------------------
  assign interval_done = supply_ok & sec_tick &
    (batt_secs == BATT_W'(BATT_SECS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batt_secs <= '0;
    end else if (power_up || !supply_ok || interval_done) begin
      batt_secs <= '0;
    end else if (sec_tick) begin
      batt_secs <= batt_secs + BATT_W'(1);
    end
  end

  assign check_now = check_pending & supply_ok;

  // A new request wins over completion of the previous one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_pending <= 1'b1;
    end else if (power_up || interval_done) begin
      check_pending <= 1'b1;
    end else if (check_now) begin
      check_pending <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_low_flag <= 1'b0;
    end else if (check_now) begin
      battery_low_flag <= battery_below;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [31:0] slow_low_run;
  logic [31:0] idle_run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_low_run <= 32'h0000_0000;
      idle_run <= 32'h0000_0000;
    end else begin
      slow_low_run <= slow_reset_request_n ? 32'h0 : slow_low_run + 32'h1;
      idle_run <= any_req ? 32'h0 : idle_run + 32'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fast_low;
    !fast_reset_request_n [*3];
  endsequence

  a_fast_assert: assert property (s_fast_low |-> ##2 reset_out_oe)
    else $error("fast request did not assert reset in time");
  a_fast_qualify: assert property ($rose(fast_qual) |->
    $past(!fast_reset_request_n, 1) && $past(!fast_reset_request_n, 2) &&
    $past(!fast_reset_request_n, 3))
    else $error("fast request qualified on a short pulse");
  a_slow_persist: assert property (
    $rose(slow_qual) |-> slow_low_run == SLOW_QUAL)
    else $error("slow request qualified at wrong time");
  a_hold_while_req: assert property (any_req |=> reset_out_oe)
    else $error("reset released while request active");
  a_release_delay: assert property (
    $fell(reset_out_oe) |-> idle_run == HOLD)
    else $error("reset released at wrong delay");
  a_ft_gate: assert property (
    !ft_cond |=> !interrupt_freqtest_out_oe)
    else $error("test output driven while gated");
  a_ft_rate: assert property ($changed(ft_wave) |->
    $past(osc_run) && $past(ft_cnt) == FT_W'(FT_HALF_TICKS - 1))
    else $error("test wave toggled off its count");
  a_batt_set: assert property (
    check_now |=> battery_low_flag == $past(battery_below))
    else $error("battery check not recorded");
  a_batt_keep: assert property (
    !check_now |=> $stable(battery_low_flag))
    else $error("battery flag changed without check");
  a_pdown_clear: assert property (power_down |=>
    !day[FT_BIT] && watchdog == 8'h00 && !control[W_BIT] && !control[R_BIT])
    else $error("power-down did not clear bits");
  a_pdown_keep: assert property (power_down |=> $stable(alarm_month))
    else $error("power-down changed alarm enables");
  a_reset_clear: assert property (reset_clear |=>
    !alarm_month[AFE_BIT] && !alarm_month[ABE_BIT] &&
    !alarm_month[SQUARE_WAVE_ENABLE_BIT] && watchdog == 8'h00 && !day[FT_BIT] &&
    $stable(control[SIGN_BIT:0]) && $stable(seconds))
    else $error("reset event did not clear bits");

endmodule

// File: core/rcs_pkg.sv
// Constants for the clock supervision and calibration block.
// Assumes a 50 MHz APB clock and a synchronous oscillator tick input.
// Behaviour
// - Either active-low reset request gives a power-cycle style reset.
// - Low pulses shorter than an input's qualification delay are ignored.
// - Fast request low drives the reset output low within 50 to 200 ns.
// - Slow request must stay low 20 to 100 ms before reset asserts.
// - Reset output stays asserted 40 to 200 ms after requests return high.
// - Oscillator is 32,768 Hz; calibration acts at the divide-by-256 stage.
// - Calibration magnitude: five unsigned bits, 0 to 31, control low bits.
// - Bit above magnitude: one speeds the clock up, zero slows it.
// - 64-minute cycle; affected seconds shortened by 128 or lengthened by 256.
// - Magnitude N modifies only the first 2N minutes of each cycle.
// - 512 Hz test output runs when stop, test, alarm, watchdog terms allow.
// - Test output is taken before calibration, which never shifts it.
// - Frequency test enable is cleared whenever main power goes down.
// - Battery checked at power-up and every 24 hours, only on supply.
// - A low battery check sets the battery-low flag, flags bit 4.
// - Battery-low flag holds until a later check finds a good battery.
// - Power-up clears hold bits, test, alarm enables, square wave, watchdog.
// - Reset event clears the same bits and leaves other control bits alone.
// - Power-down clears hold bits, test and watchdog; alarm bits are kept.

package rcs_pkg;

  // --------------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned FAST_DELAY_MIN_NS = 50;
  localparam int unsigned FAST_QUAL_CYC =
    (FAST_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOW_DELAY_MIN_MS = 20;
  localparam int unsigned SLOW_QUAL_CYC = SLOW_DELAY_MIN_MS * CYC_PER_MS;
  localparam int unsigned RELEASE_DELAY_MIN_MS = 40;
  localparam int unsigned HOLD_CYC = RELEASE_DELAY_MIN_MS * CYC_PER_MS;
  localparam int unsigned BATT_INTERVAL_H = 24;
  localparam int unsigned BATT_INTERVAL_S = BATT_INTERVAL_H * 3600;

  // --------------------------------------------------------------------------
  // Oscillator divider and calibration
  // --------------------------------------------------------------------------
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned CAL_STAGE_DIV = 256;
  localparam int unsigned STAGE_TICKS_PER_SEC = OSC_HZ / CAL_STAGE_DIV;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned CAL_CYCLE_MIN = 64;
  localparam int unsigned CAL_LAST_MIN = 62;
  localparam int unsigned CAL_SHORTEN_CYC = 128;
  localparam int unsigned CAL_LENGTHEN_CYC = 256;
  localparam int unsigned CAL_MAG_W = 5;
  localparam int unsigned FT_HZ = 512;
  localparam int unsigned FT_HALF_TICKS = OSC_HZ / (2 * FT_HZ);

  // --------------------------------------------------------------------------
  // Register map: indices, byte address is four times the index
  // --------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned IDX_W = 19;
  localparam logic [IDX_W-1:0] IDX_FLAGS_STATUS = 19'h7fff0;
  localparam logic [IDX_W-1:0] IDX_ALARM_MONTH_CONTROL = 19'h7fff6;
  localparam logic [IDX_W-1:0] IDX_WATCHDOG_SETTING = 19'h7fff7;
  localparam logic [IDX_W-1:0] IDX_CONTROL_CALIBRATION = 19'h7fff8;
  localparam logic [IDX_W-1:0] IDX_SECONDS_AND_STOP = 19'h7fff9;
  localparam logic [IDX_W-1:0] IDX_DAY_AND_FREQ_TEST = 19'h7fffc;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int unsigned BL_BIT = 4;
  localparam int unsigned AFE_BIT = 7;
  localparam int unsigned SQUARE_WAVE_ENABLE_BIT = 6;
  localparam int unsigned ABE_BIT = 5;
  localparam int unsigned WDS_BIT = 7;
  localparam int unsigned W_BIT = 7;
  localparam int unsigned R_BIT = 6;
  localparam int unsigned SIGN_BIT = 5;
  localparam int unsigned ST_BIT = 7;
  localparam int unsigned FT_BIT = 6;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// File: core/rcs_low_filter.sv
// Low-level qualification filter for one active-low request.
// Assumes the request is synchronous to pclk.
`timescale 1ns/10ps

module rcs_low_filter
  import rcs_pkg::*;
#(
  parameter int unsigned QUAL = FAST_QUAL_CYC,
  parameter int unsigned CNT_W = $clog2(QUAL + 1)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request and result
  input wire logic req_n,
  output logic qualified
);

  logic [CNT_W-1:0] low_cnt;

  // Counts consecutive low samples; any high sample restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= '0;
    end else if (req_n) begin
      low_cnt <= '0;
    end else if (low_cnt != CNT_W'(QUAL)) begin
      low_cnt <= low_cnt + CNT_W'(1);
    end
  end

  assign qualified = (low_cnt == CNT_W'(QUAL));

endmodule

// File: core/rcs_cal_divider.sv
// Calibrated oscillator divider producing one tick per second.
// Assumes osc_run pulses once per running oscillator cycle.
`timescale 1ns/10ps

module rcs_cal_divider
  import rcs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Oscillator and calibration setting
  input wire logic osc_run,
  input wire logic [CAL_MAG_W-1:0] cal_mag,
  input wire logic cal_pos,
  // Divided output
  output logic sec_tick
);

  localparam int LEN_W = $clog2(CAL_STAGE_DIV + CAL_LENGTHEN_CYC + 1);
  localparam int SUB_W = $clog2(STAGE_TICKS_PER_SEC);
  localparam int SEC_W = $clog2(SEC_PER_MIN);
  localparam int MIN_W = $clog2(CAL_CYCLE_MIN);

  logic [LEN_W-1:0] stage_cnt;
  logic [LEN_W-1:0] period_len;
  logic [SUB_W-1:0] sub_cnt;
  logic [SEC_W-1:0] sec_cnt;
  logic [MIN_W-1:0] min_cnt;
  logic adjust_now;
  logic stage_wrap;
  logic sub_wrap;

  // --------------------------------------------------------------------------
  // Correction window: first stage period of second 0, first 2N minutes
  // --------------------------------------------------------------------------
  assign adjust_now = (sec_cnt == '0) && (sub_cnt == '0) &&
    (min_cnt < {cal_mag, 1'b0});

  // Split shortens the stage period, blanking stretches it
  always_comb begin
    period_len = LEN_W'(CAL_STAGE_DIV);
    if (adjust_now && cal_pos) begin
      period_len = LEN_W'(CAL_STAGE_DIV - CAL_SHORTEN_CYC);
    end else if (adjust_now) begin
      period_len = LEN_W'(CAL_STAGE_DIV + CAL_LENGTHEN_CYC);
    end
  end

  // A setting change mid-period may leave the count past the new end
  assign stage_wrap = (stage_cnt >= period_len - LEN_W'(1));
  assign sub_wrap = (sub_cnt == SUB_W'(STAGE_TICKS_PER_SEC - 1));

  // --------------------------------------------------------------------------
  // Divider chain
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_cnt <= '0;
      sub_cnt <= '0;
      sec_cnt <= '0;
      min_cnt <= '0;
    end else if (osc_run) begin
      if (stage_wrap) begin
        stage_cnt <= '0;
        sub_cnt <= sub_cnt + SUB_W'(1);
        if (sub_wrap && sec_cnt == SEC_W'(SEC_PER_MIN - 1)) begin
          sec_cnt <= '0;
          min_cnt <= min_cnt + MIN_W'(1);
        end else if (sub_wrap) begin
          sec_cnt <= sec_cnt + SEC_W'(1);
        end
      end else begin
        stage_cnt <= stage_cnt + LEN_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= osc_run && stage_wrap && sub_wrap;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cal_window: assert property (
    (min_cnt >= {cal_mag, 1'b0}) |-> period_len == LEN_W'(CAL_STAGE_DIV))
    else $error("calibration applied outside 2N minutes");
  a_cal_cycle_end: assert property (
    (min_cnt >= MIN_W'(CAL_LAST_MIN)) |-> !adjust_now)
    else $error("calibration applied in last two minutes");

endmodule

// File: verification/rcs_host.sv
// Host model: APB master that reaches the supervisor's registers.
// Assumes one bench process calls xfer, entered just after a rising edge.
`timescale 1ns/10ps

module rcs_host
  import rcs_pkg::*;
(
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic hung;

  initial begin
    hung = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end

  // One transfer; request held until pready is seen high or 50 edges have passed
  task automatic xfer(input logic w, input logic [IDX_W-1:0] idx,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hung = 1'b1;
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// File: verification/tb_rcs_supervisor.sv
// Self-checking bench for the supervision and calibration block.
// Assumes short SLOW_QUAL and HOLD values and an osc tick every 2 clocks.
`timescale 1ns/10ps

module tb_rcs_supervisor;
  import rcs_pkg::*;
  localparam int unsigned SQ = 20;
  localparam int unsigned HD = 40;
  localparam logic [IDX_W-1:0] FLG = IDX_FLAGS_STATUS;
  localparam logic [IDX_W-1:0] AMC = IDX_ALARM_MONTH_CONTROL;
  localparam logic [IDX_W-1:0] WDG = IDX_WATCHDOG_SETTING;
  localparam logic [IDX_W-1:0] CTL = IDX_CONTROL_CALIBRATION;
  localparam logic [IDX_W-1:0] DAY = IDX_DAY_AND_FREQ_TEST;
  logic pclk = 0, presetn = 0, osc_en = 0, osc_tick = 0;
  logic supply_ok = 1, battery_below = 0;
  logic fast_reset_request_n = 1, slow_reset_request_n = 1;
  logic psel, penable, pwrite, pready, pslverr, rst_oe, irq_oe, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] q, d;
  int errors = 0, n_checks = 0, h;

  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) osc_tick <= osc_en & ~osc_tick;

  rcs_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
                   .prdata, .pready, .pslverr);
  rcs_supervisor #(.SLOW_QUAL(SQ), .HOLD(HD), .BATT_SECS(3))
    i_rcs_supervisor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .osc_tick,
    .supply_ok, .battery_below, .fast_reset_request_n,
    .slow_reset_request_n, .reset_out_i(~rst_oe), .reset_out_o(),
    .reset_out_oe(rst_oe), .interrupt_freqtest_out_i(~irq_oe),
    .interrupt_freqtest_out_o(), .interrupt_freqtest_out_oe(irq_oe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic rd(input logic [IDX_W-1:0] i);
    u_host.xfer(1'b0, i, 8'h00, q, e);
  endtask
  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] v);
    u_host.xfer(1'b1, i, v, q, e);
  endtask

  // Hold one request low for n edges, then release it
  task automatic pulse(input bit fast, input int n);
    if (fast) fast_reset_request_n <= 1'b0;
    else slow_reset_request_n <= 1'b0;
    repeat (n) @(posedge pclk);
    fast_reset_request_n <= 1'b1;
    slow_reset_request_n <= 1'b1;
  endtask

  // Edges until the reset output lets go
  task automatic wait_rel;
    int n;
    for (n = 0; n < 500 && rst_oe !== 1'b0; n++) @(posedge pclk);
    if (n == 500) begin
      errors++;
      close_out();
    end
    chk(n >= HD - 4 && n <= HD + 4, 1);
  endtask

  // Length of one full half period of the test output, 0 if it stands
  task automatic meas(output int n);
    logic p;
    int i;
    n = 0;
    p = irq_oe;
    for (i = 0; i < 200 && irq_oe === p; i++) @(posedge pclk);
    p = irq_oe;
    if (i < 200)
      for (n = 0; n < 200 && irq_oe === p; n++) @(posedge pclk);
    // A single change followed by a standing level is no wave
    if (n == 200) n = 0;
  endtask

  function automatic int half_exp();
    return FT_HALF_TICKS * 2;
  endfunction

  initial begin
    void'($urandom(32'hcea7cb04));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(rst_oe, 1);
    wait_rel();
    rd(WDG);
    chk(q, 8'h00);
    rd(CTL);
    chk(q, 8'h00);
    rd(19'h00010);
    chk({e, q}, 9'h100);
    d = 8'($urandom);
    wr(CTL, d);
    rd(CTL);
    chk(q, d);
    wr(WDG, 8'h85);
    pulse(1, 2);
    repeat (4) @(posedge pclk);
    chk(rst_oe, 0);
    pulse(1, 3);
    repeat (2) @(posedge pclk);
    chk(rst_oe, 1);
    wait_rel();
    rd(CTL);
    chk(q, d & 8'h3f);
    rd(WDG);
    chk(q, 8'h00);
    pulse(0, SQ - 1);
    repeat (3) @(posedge pclk);
    chk(rst_oe, 0);
    pulse(0, SQ + 1);
    repeat (3) @(posedge pclk);
    chk(rst_oe, 1);
    wait_rel();
    pulse(1, HD + 20);
    chk(rst_oe, 1);
    wait_rel();
    wr(AMC, 8'h00);
    wr(IDX_SECONDS_AND_STOP, 8'h00);
    wr(DAY, 8'h40);
    osc_en <= 1'b1;
    repeat (300) @(posedge pclk);
    meas(h);
    chk(h, half_exp());
    wr(CTL, 8'h3f);
    meas(h);
    chk(h, half_exp());
    wr(WDG, 8'h80);
    meas(h);
    chk(h, half_exp());
    wr(AMC, 8'he0);
    meas(h);
    chk(h, 0);
    chk(irq_oe, 0);
    wr(DAY, 8'h40);
    wr(WDG, 8'h85);
    battery_below <= 1'b1;
    supply_ok <= 1'b0;
    repeat (5) @(posedge pclk);
    supply_ok <= 1'b1;
    wait_rel();
    rd(DAY);
    chk(q[6], 0);
    rd(WDG);
    chk(q, 8'h00);
    battery_below <= 1'b0;
    wr(FLG, 8'h00);
    rd(FLG);
    chk(q[BL_BIT], 1);
    supply_ok <= 1'b0;
    repeat (5) @(posedge pclk);
    supply_ok <= 1'b1;
    wait_rel();
    rd(FLG);
    chk(q[BL_BIT], 0);
    chk(u_host.hung, 0);
    close_out();
  end

  initial begin
    #2000000;
    errors++;
    close_out();
  end
endmodule
